/* File: inc/sbl_pkg.sv */
// constants, types and reset values of the legacy stripe buffer shift-out
`default_nettype none
package sbl_pkg;
  localparam int unsigned CNT_W = 14;
  localparam int unsigned POS_W = 11;
  localparam int unsigned OFF_W = 10;
  localparam int unsigned RST_W = 20;
  localparam int unsigned CLK_MHZ = 250;

  // buffer geometry
  localparam logic [OFF_W-1:0] TRACK_BITS = 10'h260;  // 608 per track
  localparam logic [1:0]       NUM_TRACKS = 2'h3;
  localparam logic [POS_W-1:0] LAST_POS   = 11'h71F;  // 3*608-1
  localparam logic [POS_W-1:0] TRACK_B_BASE = 11'h260;
  localparam logic [POS_W-1:0] TRACK_C_BASE = 11'h4C0;

  // strobe pulse budget: 2 + 16 + 8*3*608
  localparam logic [CNT_W-1:0] PREAMBLE_BITS = 14'h0010;
  localparam logic [CNT_W-1:0] DATA_END      = 14'h3910;  // 16 + 14592
  localparam logic [CNT_W-1:0] RESET_PULSES  = 14'h3912;  // 14610

  // revision word sent first; value is arbitrary
  localparam logic [15:0] PREAMBLE = 16'h5A01;

  // internal reset routine, least time 3 ms
  localparam longint unsigned RST_INT_NS = 3000000;
  localparam int unsigned RST_INT_CYC =
    32'((RST_INT_NS * CLK_MHZ + 999) / 1000);

  typedef enum logic [4:0] {
    ST_INIT    = 5'h01,
    ST_ARMED   = 5'h02,
    ST_READY   = 5'h04,
    ST_EXTRACT = 5'h08,
    ST_NEWMODE = 5'h10
  } sbl_state_t;

  // one decoded card bit from the flux decoder
  typedef struct packed {
    logic       valid;
    logic       value;
    logic [1:0] track;
  } sbl_card_bit_t;

  typedef struct packed {
    sbl_state_t            state;
    logic [2:0]            stb_sync;
    logic                  stb;
    logic [2:0]            dat_sync;
    logic [RST_W-1:0]      rst_cnt;
    logic                  mode_new;
    logic [CNT_W-1:0]      cnt;
    logic [POS_W-1:0]      pos;
    logic                  dir;
    logic [2:0][OFF_W-1:0] wr_cnt;
    logic [2:0]            started;
    logic                  data_out;
    logic                  data_oe_n;
  } sbl_regs_t;

  localparam sbl_regs_t SBL_RESET = '{
    state:     ST_INIT,
    stb_sync:  3'h7,
    stb:       1'h1,
    dat_sync:  3'h7,
    rst_cnt:   20'h00000,
    mode_new:  1'h0,
    cnt:       14'h0000,
    pos:       11'h000,
    dir:       1'h0,
    wr_cnt:    30'h00000000,
    started:   3'h0,
    data_out:  1'h1,
    data_oe_n: 1'h1
  };
endpackage
`default_nettype wire

/* File: rtl/sbl_shiftout.sv */
// legacy-mode serial shift-out of a three-track stripe buffer
`timescale 1ns/100ps
`default_nettype none
module sbl_shiftout #(
  parameter int unsigned RST_INT_CYCLES = sbl_pkg::RST_INT_CYC
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  strobe_in,
  input  wire logic                  data_in,
  output logic                       data_out,
  output logic                       data_oe_n,
  input  wire sbl_pkg::sbl_card_bit_t card_bit,
  input  wire logic                  swipe_done,
  output logic                       mode_new,
  output logic                       armed
);

  sbl_pkg::sbl_regs_t                r;
  sbl_pkg::sbl_regs_t                next_r;
  logic [sbl_pkg::LAST_POS:0]        store;
  logic                              wr_en;
  logic [sbl_pkg::POS_W-1:0]         wr_addr;
  logic                              stb_rise;
  logic                              stb_fall;
  logic                              in_data;
  logic [1:0]                        t;

  // first buffer position of a track
  function automatic logic [sbl_pkg::POS_W-1:0] track_base(
    input logic [1:0] trk
  );
    track_base = 11'h000;
    if (trk == 2'h1)
      track_base = sbl_pkg::TRACK_B_BASE;
    else if (trk == 2'h2)
      track_base = sbl_pkg::TRACK_C_BASE;
  endfunction

  // level the output shows for a given pulse index; low means one
  function automatic logic shift_level(
    input logic [sbl_pkg::CNT_W-1:0] idx,
    input logic                      stored
  );
    if (idx < sbl_pkg::PREAMBLE_BITS)
      shift_level = ~sbl_pkg::PREAMBLE[idx[3:0]];
    else if (idx < sbl_pkg::DATA_END)
      shift_level = ~stored;
    else
      shift_level = 1'h1;
  endfunction

  // strobe edges count only once the 2nd and 3rd stages agree
  assign stb_rise = (r.stb_sync[1] == r.stb_sync[2]) && r.stb_sync[2]
                    && !r.stb;
  assign stb_fall = (r.stb_sync[1] == r.stb_sync[2]) && !r.stb_sync[2]
                    && r.stb;
  assign in_data  = (r.cnt >= sbl_pkg::PREAMBLE_BITS)
                    && (r.cnt < sbl_pkg::DATA_END);
  assign t        = card_bit.track;

  // next-state logic of the whole block
  always_comb
  begin
    next_r = r;
    wr_en = 1'h0;
    wr_addr = 11'h000;
    next_r.stb_sync = {r.stb_sync[1:0], strobe_in};
    next_r.dat_sync = {r.dat_sync[1:0], data_in};
    if (r.stb_sync[1] == r.stb_sync[2])
      next_r.stb = r.stb_sync[2];
    unique case (r.state)
      sbl_pkg::ST_INIT:
      begin
        // pin released so the controller may pull it for mode select
        next_r.data_oe_n = 1'h1;
        next_r.data_out = 1'h1;
        next_r.cnt = 14'h0000;
        next_r.pos = 11'h000;
        next_r.dir = 1'h0;
        next_r.wr_cnt = '0;
        next_r.started = 3'h0;
        if (r.rst_cnt >= sbl_pkg::RST_W'(RST_INT_CYCLES - 1))
        begin
          next_r.rst_cnt = 20'h00000;
          if (r.mode_new || (!r.dat_sync[1] && !r.dat_sync[2]))
          begin
            next_r.mode_new = 1'h1;
            next_r.state = sbl_pkg::ST_NEWMODE;
          end
          else
          begin
            // legacy has no off state: straight to armed
            next_r.state = sbl_pkg::ST_ARMED;
            next_r.data_oe_n = 1'h0;
          end
        end
        else
          next_r.rst_cnt = r.rst_cnt + 20'h00001;
      end
      sbl_pkg::ST_ARMED:
      begin
        // strobe is held high here and is not looked at
        next_r.data_oe_n = 1'h0;
        next_r.data_out = 1'h1;
        if (card_bit.valid && (t < sbl_pkg::NUM_TRACKS)
            && (r.started[t] || card_bit.value)
            && (r.wr_cnt[t] < sbl_pkg::TRACK_BITS))
        begin
          // storage begins at the first one bit; overflow is dropped
          wr_en = 1'h1;
          wr_addr = track_base(t) + sbl_pkg::POS_W'(r.wr_cnt[t]);
          next_r.wr_cnt[t] = r.wr_cnt[t] + 10'h001;
          next_r.started[t] = 1'h1;
        end
        if (swipe_done)
        begin
          next_r.data_out = 1'h0;
          next_r.state = sbl_pkg::ST_READY;
        end
      end
      sbl_pkg::ST_READY:
      begin
        // later card bits are ignored until the next reset
        if (stb_fall)
        begin
          next_r.state = sbl_pkg::ST_EXTRACT;
          next_r.cnt = 14'h0000;
          next_r.data_out = shift_level(14'h0000, 1'h0);
        end
      end
      sbl_pkg::ST_EXTRACT:
      begin
        if (stb_fall)
          next_r.data_out = shift_level(r.cnt, store[r.pos]);
        if (stb_rise)
        begin
          next_r.data_out = 1'h1;
          next_r.cnt = r.cnt + 14'h0001;
          if (in_data)
          begin
            if (!r.dir)
            begin
              if (r.pos == sbl_pkg::LAST_POS)
                next_r.dir = 1'h1;
              else
                next_r.pos = r.pos + 11'h001;
            end
            else if (r.pos == 11'h000)
              next_r.dir = 1'h0;
            else
              next_r.pos = r.pos - 11'h001;
          end
          // blind strobing may run fast; only the count matters here
          if (r.cnt == sbl_pkg::RESET_PULSES - 14'h0001)
          begin
            next_r.state = sbl_pkg::ST_INIT;
            next_r.rst_cnt = 20'h00000;
            // restart here so the count never shows one past the limit
            next_r.cnt = 14'h0000;
          end
        end
      end
      sbl_pkg::ST_NEWMODE:
      begin
        // legacy logic idles; only a power cycle brings it back
        next_r.data_oe_n = 1'h1;
        next_r.data_out = 1'h1;
      end
      default:
        next_r.state = sbl_pkg::ST_INIT;
    endcase
  end

  // state register; rst stands for power-up
  always_ff @(posedge clk)
  begin
    if (rst)
      r <= sbl_pkg::SBL_RESET;
    else
      r <= next_r;
  end

  // card bit store: cleared only at power-up and by the reset routine, never by time
  always_ff @(posedge clk)
  begin
    if (rst || (r.state == sbl_pkg::ST_INIT))
      store <= '0;
    else if (wr_en)
      store[wr_addr] <= card_bit.value;
  end

  assign data_out  = r.data_out;
  assign data_oe_n = r.data_oe_n;
  assign mode_new  = r.mode_new;
  assign armed     = r.state[1];

  default clocking cb_main @(posedge clk);
  endclocking
  default disable iff (rst);

  // all checks run on the one clock and rest while rst is high, so the
  // reset values never meet a $past from before the reset
  chk_mode_sticky: assert property (r.mode_new |=> r.mode_new)
    else $error("new mode dropped without power cycle");
  chk_newmode_release: assert property
    (r.state == sbl_pkg::ST_NEWMODE |-> r.data_oe_n && !armed)
    else $error("legacy logic active in new mode");
  chk_track_limit: assert property
    (wr_en |-> r.wr_cnt[t] < sbl_pkg::TRACK_BITS)
    else $error("track store past 608 bits");
  chk_store_write: assert property
    (wr_en |=> store[$past(wr_addr)] == $past(card_bit.value))
    else $error("accepted card bit not stored");
  chk_ready_fall: assert property
    (r.state == sbl_pkg::ST_ARMED && swipe_done
     |=> !data_out && !data_oe_n ##1 !data_out)
    else $error("buffer ready not signalled low");
  chk_armed_high: assert property
    (r.state == sbl_pkg::ST_ARMED && !swipe_done
     |=> data_out && !data_oe_n)
    else $error("armed state not driving data high");
  chk_preamble_first: assert property
    (r.state == sbl_pkg::ST_READY && stb_fall
     |=> data_out == ~sbl_pkg::PREAMBLE[0])
    else $error("preamble lsb not first");
  chk_high_on_rise: assert property
    (r.state == sbl_pkg::ST_EXTRACT && stb_rise |=> data_out)
    else $error("data not high after strobe rise");
  chk_pointer_step: assert property
    (r.state == sbl_pkg::ST_EXTRACT && stb_rise && in_data && !r.dir
     && r.pos != sbl_pkg::LAST_POS |=> r.pos == $past(r.pos) + 11'h001)
    else $error("read pointer did not advance");
  chk_reset_count: assert property
    (r.state == sbl_pkg::ST_EXTRACT && stb_rise
     && r.cnt == sbl_pkg::RESET_PULSES - 14'h0001
     |=> r.state == sbl_pkg::ST_INIT && data_out)
    else $error("reset not started on final strobe");
  chk_count_clear: assert property
    (r.state == sbl_pkg::ST_EXTRACT && stb_rise
     && r.cnt == sbl_pkg::RESET_PULSES - 14'h0001 |=> r.cnt == 14'h0000)
    else $error("strobe count not cleared on reset");
  chk_count_bound: assert property
    (r.cnt < sbl_pkg::RESET_PULSES)
    else $error("strobe count passed reset count");
  chk_tail_high: assert property
    (r.state == sbl_pkg::ST_EXTRACT && stb_fall
     && r.cnt >= sbl_pkg::DATA_END |=> data_out)
    else $error("data shown after the last pass");
  chk_init_exit: assert property
    (r.state == sbl_pkg::ST_INIT |=> r.state inside
     {sbl_pkg::ST_INIT, sbl_pkg::ST_ARMED, sbl_pkg::ST_NEWMODE})
    else $error("reset routine left to wrong state");
  chk_store_hold: assert property
    (r.state != sbl_pkg::ST_INIT && !wr_en |=> store == $past(store))
    else $error("stored data changed without write");
  chk_bit_level: assert property
    (r.state == sbl_pkg::ST_EXTRACT && stb_fall && in_data
     |=> data_out == ~$past(store[r.pos]))
    else $error("data level does not match stored bit");
  chk_reverse_end: assert property
    (r.state == sbl_pkg::ST_EXTRACT && stb_rise && in_data && !r.dir
     && r.pos == sbl_pkg::LAST_POS |=> r.dir && r.pos == sbl_pkg::LAST_POS)
    else $error("pointer did not reverse at last position");

  // main scenarios: ready, readout, reversal, count reset, new mode
  cov_ready: cover property (r.state == sbl_pkg::ST_READY);
  cov_extract: cover property (r.state == sbl_pkg::ST_EXTRACT && stb_rise);
  cov_reverse: cover property
    (r.state == sbl_pkg::ST_EXTRACT && stb_rise && r.dir);
  cov_count_reset: cover property
    (r.state == sbl_pkg::ST_EXTRACT ##1 r.state == sbl_pkg::ST_INIT);
  cov_newmode: cover property (r.state == sbl_pkg::ST_NEWMODE);

endmodule
`default_nettype wire

/* File: tb/sbl_mcu_model.sv */
// controller-side model: drives the strobe and the reset pull on data
`timescale 1ns/100ps
`default_nettype none
module sbl_mcu_model (
  input  wire logic clk,
  input  wire logic data_wire,
  output logic      strobe,
  output logic      data_pull
);
  // strobe idles high while armed; data never forced low for legacy
  initial
  begin
    strobe    = 1'h1;
    data_pull = 1'h0;
  end

  // one pulse, low then high; the wire is sampled at the end of each phase
  task automatic pulse(input int lo, input int hi, output logic d_lo,
                       output logic d_hi);
    strobe = 1'h0;
    repeat (lo) @(negedge clk);
    d_lo = data_wire;
    strobe = 1'h1;
    repeat (hi) @(negedge clk);
    d_hi = data_wire;
  endtask

  // reset request by data pull; starts and ends with the strobe high
  task automatic reset_request();
    repeat (43) @(negedge clk);
    data_pull = 1'h1;
    repeat (1125) @(negedge clk);
    strobe = 1'h0;
    repeat (5) @(negedge clk);
    data_pull = 1'h0;
    repeat (59) @(negedge clk);
    strobe = 1'h1;
    repeat (64) @(negedge clk);
  endtask
endmodule
`default_nettype wire

/* File: tb/test_sbl_shiftout.sv */
// bench: random card bits stored, strobe readout compared with a model
`timescale 1ns/100ps
`default_nettype none
module test_sbl_shiftout;
  localparam int RC   = 20;  // shortened reset routine
  localparam int N    = 608;
  localparam int SL   = 64;  // at least 250 ns per phase
  localparam int LAST = 16 + 8 * 3 * N + 1;
  logic                   clk        = 1'h0;
  logic                   rst        = 1'h1;
  logic                   swipe_done = 1'h0;
  sbl_pkg::sbl_card_bit_t card_bit   = '0;
  logic                   strobe;
  logic                   data_pull;
  logic                   data_out;
  logic                   data_oe_n;
  logic                   mode_new;
  logic                   armed;
  logic                   wire_lvl;
  logic                   d_lo;
  logic                   d_hi;
  int                     errors     = 0;
  int                     n_checks   = 0;
  int                     k;
  int                     w;
  int                     p;
  int                     t;
  int                     v;
  bit                     q[3][$];
  bit                     started[3];

  // pull-up wins whenever nobody drives the line
  assign wire_lvl = data_oe_n === 1'h0 ? data_out : !data_pull;

  always #2 clk = ~clk;

  sbl_shiftout #(.RST_INT_CYCLES(RC)) uut (
    .clk        (clk),
    .rst        (rst),
    .strobe_in  (strobe),
    .data_in    (wire_lvl),
    .data_out   (data_out),
    .data_oe_n  (data_oe_n),
    .card_bit   (card_bit),
    .swipe_done (swipe_done),
    .mode_new   (mode_new),
    .armed      (armed)
  );

  sbl_mcu_model mcu (
    .clk       (clk),
    .data_wire (wire_lvl),
    .strobe    (strobe),
    .data_pull (data_pull)
  );

  task automatic finish_test;
    $display("errors %0d checks %0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask

  function automatic logic sig(input int sel);
    logic [1:0] s;
    s = {mode_new, armed};
    return s[sel];
  endfunction

  // bounded wait; the caller checks the outcome
  task automatic wait_for(input int sel, input logic val, input int lim);
    for (w = 0; w < lim && sig(sel) !== val; w++)
      @(negedge clk);
  endtask

  // wire level expected at pulse k; low means a one
  function automatic logic exp_bit(input int k);
    int d;
    int pos;
    if (k < 16)
      return !sbl_pkg::PREAMBLE[k];
    if (k >= 16 + 8 * 3 * N)
      return 1'h1;
    d = (k - 16) % (3 * N);
    pos = ((k - 16) / (3 * N)) % 2 ? 3 * N - 1 - d : d;
    if (pos % N < q[pos / N].size())
      return !q[pos / N][pos % N];
    return 1'h1;
  endfunction

  // watchdog about a third above the expected run of some 110000 cycles
  initial
  begin
    repeat (150000) @(posedge clk);
    errors++;
    finish_test();
  end

  initial
  begin
    v = $urandom(3042);
    repeat (16) @(negedge clk);
    rst = 1'h0;
    wait_for(0, 1'h1, RC + 20);
    check(armed, 1'h1, "not armed after reset");
    check(mode_new, 1'h0, "new mode at start");
    check(data_oe_n, 1'h0, "data released when armed");
    // track A overflows; random tracks after, track 3 must be dropped
    for (int i = 0; i < 1400; i++)
    begin
      t = i < 660 ? 0 : $urandom % 4;
      v = $urandom % 2;
      card_bit = '{valid: 1'h1, value: v[0], track: t[1:0]};
      if (t < 3 && (started[t] || v) && q[t].size() < N)
      begin
        q[t].push_back(v[0]);
        started[t] = 1'b1;
      end
      @(negedge clk);
    end
    card_bit = '0;
    repeat (500) @(negedge clk);
    check(wire_lvl, 1'h1, "early card indication");
    swipe_done = 1'h1;
    @(negedge clk);
    swipe_done = 1'h0;
    @(negedge clk);
    check(wire_lvl, 1'h0, "no ready fall");
    repeat (5) @(negedge clk);
    // full timing near boundaries only; compressed pulses elsewhere
    for (k = 0; k <= LAST; k++)
    begin
      p = (k - 16) % (3 * N);
      if (k < 20 || k > LAST - 4 || p % N < 2 || p % N > N - 3)
      begin
        mcu.pulse(SL, SL, d_lo, d_hi);
        check(d_lo, exp_bit(k), "data bit");
        check(d_hi, 1'h1, "not high after rise");
        check(armed, k == LAST, "rearm by count");
      end
      else
        // blind pulses run past the rate limit to keep the run short; the
        // three-stage synchroniser still needs two cycles per phase; three are given
        mcu.pulse(3, 3, d_lo, d_hi);
    end
    check(mode_new, 1'h0, "left legacy on count reset");
    // new mode chosen by a low data line, then sticks
    mcu.data_pull = 1'h1;
    rst = 1'h1;
    repeat (16) @(negedge clk);
    rst = 1'h0;
    wait_for(1, 1'h1, RC + 20);
    check(mode_new, 1'h1, "new mode not taken");
    mcu.data_pull = 1'h0;
    for (k = 0; k < 20; k++)
      mcu.pulse(SL, SL, d_lo, d_hi);
    check(mode_new, 1'h1, "left new mode");
    check(armed, 1'h0, "legacy arm in new mode");
    check(data_oe_n, 1'h1, "data driven in new mode");
    // neither a data-pull reset nor a long clearing pulse brings legacy back
    mcu.reset_request();
    mcu.pulse(SL, 275, d_lo, d_hi);
    check(mode_new, 1'h1, "legacy after reset request");
    check(armed, 1'h0, "armed after reset request");
    finish_test();
  end
endmodule
`default_nettype wire
